// File: design/preset_table.sv
// Preset speed table: sixteen presets and two jog words, registered read
`timescale 1ns/1ps
module preset_table
  import refsel_pkg::*;
(
  input  wire logic     clk,
  ref_mem_if.table_side mem
);
  logic [REF_W-1:0] word_reg [MEM_DEPTH];

  // No reset on the array so it maps onto RAM; contents are software's job
  always_ff @(posedge clk)
  begin
    if (mem.wr_en)
    begin
      word_reg[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    mem.rd_data <= word_reg[mem.rd_addr];
  end
endmodule

// File: design/pulse_rate_meter.sv
// Counts pulse edges over a gate window and scales them to a reference
`timescale 1ns/1ps
module pulse_rate_meter
  import refsel_pkg::*;
#(
  parameter int GATE = GATE_CYCLES
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             pulse_edge,
  input  wire logic [REF_W-1:0] scale,
  output logic      [REF_W-1:0] rate_ref
);
  logic [31:0]      gate_reg;
  logic [CNT_W-1:0] edge_cnt_reg;
  logic             gate_end;
  logic [39:0]      quotient;

  assign gate_end = (gate_reg == 32'(GATE - 1));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gate_reg <= '0;
    else if (gate_end)
      gate_reg <= '0;
    else
      gate_reg <= gate_reg + 32'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      edge_cnt_reg <= '0;
    else if (gate_end)
      edge_cnt_reg <= CNT_W'(pulse_edge);
    else if (pulse_edge && !(&edge_cnt_reg))
      edge_cnt_reg <= edge_cnt_reg + CNT_W'(1);
  end

  // A rate equal to scale maps to full scale; above 100 percent is clamped
  always_comb
  begin
    quotient = '0;
    if (scale != '0)
      quotient = (40'(edge_cnt_reg) * 40'(REF_FULL)) / 40'(scale);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rate_ref <= '0;
    else if (gate_end)
      rate_ref <= (quotient > 40'(REF_FULL)) ? REF_FULL : quotient[REF_W-1:0];
  end

  a_full_scale_map : assert property (@(posedge clk) disable iff (!nrst)
    (gate_end && scale != '0 && 40'(edge_cnt_reg) == 40'(scale))
      |=> (rate_ref == REF_FULL))
    else $error("Pulse rate equal to scale did not give full reference");
endmodule

// File: design/ref_mem_if.sv
// Interface between the selector and its preset table
`timescale 1ns/1ps
interface ref_mem_if;
  import refsel_pkg::*;
  logic                      wr_en;
  logic [ADDR_W-1:0]         wr_addr;
  logic [REF_W-1:0]          wr_data;
  logic [ADDR_W-1:0]         rd_addr;
  logic [REF_W-1:0]          rd_data;

  modport table_side (input wr_en, input wr_addr, input wr_data, input rd_addr,
                      output rd_data);
  modport user_side  (output wr_en, output wr_addr, output wr_data, output rd_addr,
                      input rd_data);
endinterface

// File: design/refsel_pkg.sv
// Constants shared by the speed reference selector and its helpers
package refsel_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int REF_W   = 16;
  localparam int FN_W    = 7;
  localparam int SRC_W   = 3;
  localparam int AUX_W   = 5;
  localparam int ADDR_W  = 5;
  localparam int CNT_W   = 20;
  localparam int N_TERM  = 5;

  // ****************************************************************
  // Settings and codes
  // ****************************************************************
  localparam logic [SRC_W-1:0] SRC_KEYPAD    = 3'h0;
  localparam logic [SRC_W-1:0] SRC_ANALOG    = 3'h1;
  localparam logic [SRC_W-1:0] SRC_PULSE     = 3'h4;
  localparam logic [SRC_W-1:0] SRC_RESET     = SRC_ANALOG;
  localparam logic [AUX_W-1:0] AUX_FN_REF    = 5'h02;
  localparam logic [2:0]       PULSE_FN_FREQ = 3'h0;
  localparam logic [REF_W-1:0] SCALE_DEFAULT = 16'h05a0;
  localparam logic [FN_W-1:0]  FN_STEP1      = 7'h03;
  localparam logic [FN_W-1:0]  FN_STEP2      = 7'h04;
  localparam logic [FN_W-1:0]  FN_STEP3      = 7'h05;
  localparam logic [FN_W-1:0]  FN_JOG        = 7'h06;
  localparam logic [FN_W-1:0]  FN_STEP4      = 7'h20;
  localparam logic [FN_W-1:0]  FN_JOG2       = 7'h45;

  // Full scale: 10000 counts = 100.00 percent
  localparam logic [REF_W-1:0] REF_FULL      = 16'h2710;

  // ****************************************************************
  // Preset table layout
  // ****************************************************************
  localparam int               N_PRESET      = 16;
  localparam int               N_STEPS       = 17;
  localparam int               MEM_DEPTH     = 32;
  localparam logic [ADDR_W-1:0] ADDR_PRESET1 = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_JOG     = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_JOG2    = 5'h11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ       = 25000000;
  localparam int GATE_TIME_MS = 1000;
  localparam int GATE_CYCLES  = CLK_HZ / 1000 * GATE_TIME_MS;

  typedef enum logic [1:0]
  {
    K_MEM   = 2'b00,
    K_VOLT  = 2'b01,
    K_DUAL  = 2'b11,
    K_PULSE = 2'b10
  } pick_t;

endpackage

// File: design/speed_reference_selector.sv
// Frequency reference source and multi-step speed selection
`timescale 1ns/1ps
module speed_reference_selector
  import refsel_pkg::*;
#(
  parameter int GATE = GATE_CYCLES
)
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   digital_in_third,
  input  wire logic                   digital_in_fourth,
  input  wire logic                   digital_in_fifth,
  input  wire logic                   digital_in_sixth,
  input  wire logic                   digital_in_seventh,
  input  wire logic                   pulse_train_pin,
  input  wire logic [refsel_pkg::FN_W-1:0]   input3_function,
  input  wire logic [refsel_pkg::FN_W-1:0]   input4_function,
  input  wire logic [refsel_pkg::FN_W-1:0]   input5_function,
  input  wire logic [refsel_pkg::FN_W-1:0]   input6_function,
  input  wire logic [refsel_pkg::FN_W-1:0]   input7_function,
  input  wire logic                   three_wire_mode,
  input  wire logic [refsel_pkg::SRC_W-1:0]  ref_source_select,
  input  wire logic                   ref_source_load,
  input  wire logic                   motor_running,
  input  wire logic [refsel_pkg::AUX_W-1:0]  aux_analog_function,
  input  wire logic                   analog_master_swap,
  input  wire logic [2:0]             pulse_input_function,
  input  wire logic [refsel_pkg::REF_W-1:0]  pulse_input_scale,
  input  wire logic [refsel_pkg::REF_W-1:0]  volt_analog_in,
  input  wire logic [refsel_pkg::REF_W-1:0]  dual_analog_in,
  input  wire logic [refsel_pkg::REF_W-1:0]  keypad_ref,
  input  wire logic                   keypad_load,
  input  wire logic                   preset_wr_en,
  input  wire logic [refsel_pkg::ADDR_W-1:0] preset_wr_addr,
  input  wire logic [refsel_pkg::REF_W-1:0]  preset_wr_data,
  output logic      [refsel_pkg::REF_W-1:0]  freq_ref,
  output logic      [refsel_pkg::SRC_W-1:0]  ref_source,
  output logic                        ref_source_refused,
  output logic                        config_fault_alarm,
  output logic                        jog_active
);
  import refsel_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // True when any terminal assigned to code is on
  function automatic logic term_active(input logic [N_TERM-1:0][FN_W-1:0] fns,
                                       input logic [N_TERM-1:0]            lvl,
                                       input logic [FN_W-1:0]              code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_TERM; i++)
    begin
      hit = hit | (lvl[i] && fns[i] == code);
    end
    return hit;
  endfunction

  logic [N_TERM-1:0][FN_W-1:0] term_fn;
  logic [N_TERM-1:0]           din_meta_reg;
  logic [N_TERM-1:0]           din_sync_reg;
  logic                        pulse_meta_reg;
  logic                        pulse_sync_reg;
  logic                        pulse_prev_reg;
  logic [SRC_W-1:0]            ref_source_reg;
  logic                        refused_reg;
  logic                        fault_reg;
  logic                        jog_reg;
  logic [3:0]                  step_idx;
  logic                        jog1;
  logic                        jog2;
  pick_t                       pick_next;
  pick_t                       pick_reg;
  logic [ADDR_W-1:0]           addr_next;
  logic [ADDR_W-1:0]           addr_reg;
  logic [REF_W-1:0]            freq_ref_reg;
  logic [REF_W-1:0]            pulse_ref;

  ref_mem_if mem_bus ();

  assign term_fn = {input7_function, input6_function, input5_function,
                    input4_function, input3_function};

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end
    else
    begin
      din_meta_reg <= {digital_in_seventh, digital_in_sixth, digital_in_fifth,
                       digital_in_fourth, digital_in_third};
      din_sync_reg <= din_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulse_meta_reg <= 1'b0;
      pulse_sync_reg <= 1'b0;
      pulse_prev_reg <= 1'b0;
    end
    else
    begin
      pulse_meta_reg <= pulse_train_pin;
      pulse_sync_reg <= pulse_meta_reg;
      pulse_prev_reg <= pulse_sync_reg;
    end
  end

  pulse_rate_meter #(
    .GATE       (GATE)
  ) u_meter (
    .clk        (clk),
    .nrst       (nrst),
    .pulse_edge (pulse_sync_reg && !pulse_prev_reg),
    .scale      (pulse_input_scale),
    .rate_ref   (pulse_ref)
  );

  // ****************************************************************
  // Source setting and configuration check
  // ****************************************************************
  // Writes while running are dropped, not queued
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ref_source_reg <= SRC_RESET;
    else if (ref_source_load && !motor_running)
      ref_source_reg <= ref_source_select;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      refused_reg <= 1'b0;
    else
      refused_reg <= ref_source_load && motor_running;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fault_reg <= 1'b0;
    else
      fault_reg <= !three_wire_mode && term_active(term_fn, '1, FN_JOG2);
  end

  // ****************************************************************
  // Preset table and keypad entry
  // ****************************************************************
  // Keypad entry lands in preset 1 and wins over a table write
  assign mem_bus.wr_en   = keypad_load || preset_wr_en;
  assign mem_bus.wr_addr = keypad_load ? ADDR_PRESET1 : preset_wr_addr;
  assign mem_bus.wr_data = keypad_load ? keypad_ref : preset_wr_data;
  assign mem_bus.rd_addr = addr_next;

  preset_table u_table (
    .clk (clk),
    .mem (mem_bus.table_side)
  );

  // ****************************************************************
  // Step selection
  // ****************************************************************
  always_comb
  begin
    step_idx  = {term_active(term_fn, din_sync_reg, FN_STEP4),
                 term_active(term_fn, din_sync_reg, FN_STEP3),
                 term_active(term_fn, din_sync_reg, FN_STEP2),
                 term_active(term_fn, din_sync_reg, FN_STEP1)};
    jog1      = term_active(term_fn, din_sync_reg, FN_JOG);
    jog2      = three_wire_mode && term_active(term_fn, din_sync_reg, FN_JOG2);
    pick_next = K_MEM;
    addr_next = {1'b0, step_idx};
    if (jog1 || jog2)
    begin
      addr_next = jog1 ? ADDR_JOG : ADDR_JOG2;
    end
    else if (step_idx == 4'h0)
    begin
      case (ref_source_reg)
        SRC_ANALOG: pick_next = analog_master_swap ? K_DUAL : K_VOLT;
        SRC_PULSE:  pick_next = (pulse_input_function == PULSE_FN_FREQ) ? K_PULSE : K_MEM;
        default:    pick_next = K_MEM;
      endcase
    end
    else if (step_idx == 4'h1 && aux_analog_function == AUX_FN_REF)
    begin
      pick_next = analog_master_swap ? K_VOLT : K_DUAL;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pick_reg <= K_MEM;
      addr_reg <= ADDR_PRESET1;
      jog_reg  <= 1'b0;
    end
    else
    begin
      pick_reg <= pick_next;
      addr_reg <= addr_next;
      jog_reg  <= jog1 || jog2;
    end
  end

  // Table read is registered, so the analog paths are aligned to it here
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      freq_ref_reg <= '0;
    else
    begin
      unique case (pick_reg)
        K_MEM:   freq_ref_reg <= mem_bus.rd_data;
        K_VOLT:  freq_ref_reg <= volt_analog_in;
        K_DUAL:  freq_ref_reg <= dual_analog_in;
        K_PULSE: freq_ref_reg <= pulse_ref;
      endcase
    end
  end

  assign freq_ref           = freq_ref_reg;
  assign ref_source         = ref_source_reg;
  assign ref_source_refused = refused_reg;
  assign config_fault_alarm = fault_reg;
  assign jog_active         = jog_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_pick(pick_t k);
    ##1 (pick_reg == k);
  endsequence

  sequence s_out_volt;
    ##1 (pick_reg == K_VOLT) ##1 (freq_ref_reg == $past(volt_analog_in));
  endsequence

  sequence s_out_mem;
    ##1 (pick_reg == K_MEM) ##1 (freq_ref_reg == $past(mem_bus.rd_data));
  endsequence

  a_keypad_step_one : assert property (@(posedge clk) disable iff (!nrst)
    (ref_source_reg == SRC_KEYPAD && !jog1 && !jog2 && step_idx == 4'h0)
      |-> ##1 (addr_reg == ADDR_PRESET1) and s_out_mem)
    else $error("Keypad source did not select preset one");

  a_analog_master : assert property (@(posedge clk) disable iff (!nrst)
    (ref_source_reg == SRC_ANALOG && !analog_master_swap && !jog1 && !jog2
     && step_idx == 4'h0) |-> s_out_volt)
    else $error("Analog source did not output the voltage input");

  a_aux_switch : assert property (@(posedge clk) disable iff (!nrst)
    (!analog_master_swap && !jog1 && !jog2 && step_idx == 4'h1
     && aux_analog_function == AUX_FN_REF) |-> s_pick(K_DUAL))
    else $error("Auxiliary step did not pick second analog input");

  a_swap_master : assert property (@(posedge clk) disable iff (!nrst)
    (ref_source_reg == SRC_ANALOG && analog_master_swap && !jog1 && !jog2
     && step_idx == 4'h0) |-> s_pick(K_DUAL))
    else $error("Swapped master did not pick second analog input");

  a_pulse_source : assert property (@(posedge clk) disable iff (!nrst)
    (ref_source_reg == SRC_PULSE && pulse_input_function == PULSE_FN_FREQ
     && !jog1 && !jog2 && step_idx == 4'h0) |-> s_pick(K_PULSE) ##1 (freq_ref_reg
     == $past(pulse_ref)))
    else $error("Pulse source did not output the pulse reference");

  a_step_index : assert property (@(posedge clk) disable iff (!nrst)
    (!jog1 && !jog2) |=> (addr_reg == {1'b0, $past(step_idx)} && !jog_reg))
    else $error("Preset index not taken from preset bits");

  a_jog_priority : assert property (@(posedge clk) disable iff (!nrst)
    jog1 |=> (addr_reg == ADDR_JOG && pick_reg == K_MEM && jog_reg))
    else $error("Jog did not override preset selection");

  a_aux_other : assert property (@(posedge clk) disable iff (!nrst)
    (!jog1 && !jog2 && step_idx == 4'h1 && aux_analog_function != AUX_FN_REF)
      |-> s_pick(K_MEM))
    else $error("Step two left the stored preset");

  a_two_wire_fault : assert property (@(posedge clk) disable iff (!nrst)
    (!three_wire_mode && term_active(term_fn, '1, FN_JOG2))
      |=> config_fault_alarm)
    else $error("Second jog code in two-wire did not raise fault");

  a_source_locked : assert property (@(posedge clk) disable iff (!nrst)
    motor_running |=> ($stable(ref_source_reg) && ref_source_refused == $past(ref_source_load)))
    else $error("Source setting changed while running");
endmodule

// File: test/pulse_source.sv
// Far-side model: pulse-train generator driving the pulse input pin
`timescale 1ns/1ps
module pulse_source
#(
  parameter int PERIOD = 40
)
(
  input  wire logic clk,
  input  wire logic en,
  output logic      pin
);
  int cnt = 0;

  initial pin = 1'b0;

  // Held low while disabled so no stray edges reach the meter
  always @(negedge clk)
  begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    pin <= en && (cnt < PERIOD / 2);
  end
endmodule

// File: test/tb_speed_reference_selector.sv
// Self-checking bench for the speed reference selector
`timescale 1ns/1ps
module tb_speed_reference_selector;
  import refsel_pkg::*;

  typedef struct packed
  {
    logic [1:0]       id;
    logic [REF_W-1:0] val;
  } note_t;

  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [4:0]        din = 5'h00;
  logic              pin;
  logic              pen = 1'b0;
  logic              three_wire = 1'b0;
  logic              load = 1'b0;
  logic              running = 1'b0;
  logic [SRC_W-1:0]  src_sel = SRC_KEYPAD;
  logic [AUX_W-1:0]  aux = 5'h00;
  logic              swap = 1'b0;
  logic [2:0]        pfn = 3'h0;
  logic [REF_W-1:0]  scale = SCALE_DEFAULT;
  logic [REF_W-1:0]  va = 16'h0000;
  logic [REF_W-1:0]  vd = 16'h0000;
  logic [REF_W-1:0]  kv = 16'h0000;
  logic              kload = 1'b0;
  logic              wen = 1'b0;
  logic [ADDR_W-1:0] waddr = 5'h00;
  logic [REF_W-1:0]  wdata = 16'h0000;
  logic [FN_W-1:0]   fn [5] = '{FN_STEP1, FN_STEP2, FN_STEP3, FN_STEP4, FN_JOG};
  logic [REF_W-1:0]  freq_ref;
  logic [SRC_W-1:0]  ref_source;
  logic              refused;
  logic              alarm;
  logic              jog_active;
  logic [REF_W-1:0]  tbl [18];
  note_t             notes [$];
  event              look;
  int                fails = 0;
  int                total_checks = 0;

  always #20 clk = ~clk;

  pulse_source #(.PERIOD(40)) partner (.clk(clk), .en(pen), .pin(pin));

  speed_reference_selector #(.GATE(1000)) dut
  (
    .clk(clk), .nrst(nrst),
    .digital_in_third(din[0]), .digital_in_fourth(din[1]), .digital_in_fifth(din[2]),
    .digital_in_sixth(din[3]), .digital_in_seventh(din[4]), .pulse_train_pin(pin),
    .input3_function(fn[0]), .input4_function(fn[1]), .input5_function(fn[2]),
    .input6_function(fn[3]), .input7_function(fn[4]), .three_wire_mode(three_wire),
    .ref_source_select(src_sel), .ref_source_load(load), .motor_running(running),
    .aux_analog_function(aux), .analog_master_swap(swap), .pulse_input_function(pfn),
    .pulse_input_scale(scale), .volt_analog_in(va), .dual_analog_in(vd),
    .keypad_ref(kv), .keypad_load(kload), .preset_wr_en(wen), .preset_wr_addr(waddr),
    .preset_wr_data(wdata), .freq_ref(freq_ref), .ref_source(ref_source),
    .ref_source_refused(refused), .config_fault_alarm(alarm), .jog_active(jog_active)
  );

  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask

  // Waits out the worst pipeline latency, then hands the note over
  task automatic expect_out(logic [1:0] id, logic [REF_W-1:0] v, int w = 6);
    tick(w);
    notes.push_back('{id, v});
    -> look;
  endtask

  task automatic load_src(logic [SRC_W-1:0] v);
    src_sel = v;
    load = 1'b1;
    tick(1);
    load = 1'b0;
  endtask

  // Strobe stays up across back-to-back writes; the caller lowers it
  task automatic wr(int a, logic [REF_W-1:0] d);
    waddr = a[ADDR_W-1:0];
    wdata = d;
    wen = 1'b1;
    tick(1);
  endtask

  task automatic report_and_stop();
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************************************
  // Output watcher
  // ****************************************************************
  always @(look)
  begin
    note_t            n;
    logic [REF_W-1:0] got;
    // Several notes can arrive in one time step; drain them all
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.id)
        2'h0:    got = freq_ref;
        2'h1:    got = {13'h0000, ref_source};
        2'h2:    got = {15'h0000, alarm};
        default: got = {15'h0000, jog_active};
      endcase
      total_checks++;
      if (got !== n.val)
      begin
        fails++;
        $display("Error %0t: output %0d is %h, expected %h", $time, n.id, got, n.val);
      end
    end
  end

  initial
  begin
    #2000000;
    fails++;
    report_and_stop();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    int k;
    void'($urandom(32'h52b2afaf));
    tick(5);
    expect_out(2'h0, 16'h0000, 1);
    expect_out(2'h1, 16'h0001, 0);
    nrst = 1'b1;
    tick(1);
    for (int a = 0; a < 18; a++)
    begin
      tbl[a] = REF_W'($urandom);
      wr(a, tbl[a]);
    end
    wen = 1'b0;
    load_src(SRC_KEYPAD);
    expect_out(2'h1, 16'h0000);
    // Every preset index through the four select terminals
    for (int i = 0; i < 16; i++)
    begin
      din = {1'b0, i[3:0]};
      expect_out(2'h0, tbl[i]);
    end
    for (int i = 0; i < 16; i += 5)
    begin
      din = {1'b1, i[3:0]};
      expect_out(2'h0, tbl[16]);
      expect_out(2'h3, 16'h0001, 0);
    end
    kv = REF_W'($urandom);
    kload = 1'b1;
    tick(1);
    kload = 1'b0;
    din = 5'h00;
    expect_out(2'h0, kv);
    va = REF_W'($urandom);
    vd = REF_W'($urandom);
    load_src(SRC_ANALOG);
    expect_out(2'h0, va);
    din = 5'h01;
    expect_out(2'h0, tbl[1]);
    aux = AUX_FN_REF;
    expect_out(2'h0, vd);
    swap = 1'b1;
    expect_out(2'h0, va);
    din = 5'h00;
    expect_out(2'h0, vd);
    swap = 1'b0;
    running = 1'b1;
    load_src(SRC_PULSE);
    k = 0;
    while (refused !== 1'b1 && k < 4)
    begin
      tick(1);
      k++;
    end
    if (k == 4)
    begin
      fails++;
      $display("Error %0t: load while running not refused", $time);
      report_and_stop();
    end
    expect_out(2'h1, 16'h0001);
    running = 1'b0;
    // 25 edges per 1000-cycle window from the partner
    pen = 1'b1;
    scale = 16'h0032;
    load_src(SRC_PULSE);
    expect_out(2'h0, 16'h1388, 2600);
    scale = 16'h0019;
    expect_out(2'h0, REF_FULL, 2600);
    scale = 16'h000a;
    expect_out(2'h0, REF_FULL, 2600);
    pfn = 3'h1;
    expect_out(2'h0, kv);
    fn[4] = FN_JOG2;
    expect_out(2'h2, 16'h0001);
    three_wire = 1'b1;
    din = 5'h10;
    expect_out(2'h2, 16'h0000);
    expect_out(2'h0, tbl[17], 0);
    expect_out(2'h3, 16'h0001, 0);
    nrst = 1'b0;
    expect_out(2'h0, 16'h0000, 1);
    expect_out(2'h1, 16'h0001, 0);
    tick(2);
    report_and_stop();
  end
endmodule
